/* File: common/sclkc_defines.vh */
// Purpose: constants of the system clock mode controller
// Assumes: included by src/sclkc_top.v
// Notes: byte offsets on the AXI4-Lite register bus
`ifndef SCLKC_DEFINES_VH
`define SCLKC_DEFINES_VH

`define SCLKC_OFS_SYS_CTRL 5'h00
`define SCLKC_OFS_TG_CTRL 5'h04
`define SCLKC_OFS_INT_CTRL 5'h08
`define SCLKC_OFS_STOP_CTRL 5'h0c
`define SCLKC_OFS_STATUS 5'h10

`define SCLKC_SYS_FAST_OSC 7
`define SCLKC_SYS_SLOW_OSC 6
`define SCLKC_SYS_MAIN_SEL 5
`define SCLKC_SYS_HALT 4
`define SCLKC_SYS_TG_HALT 2
`define SCLKC_SYS_RESET 8'h80

`define SCLKC_TG_DV7 0
`define SCLKC_TG_TBSEL_LO 1
`define SCLKC_TG_TBSEL_HI 3
`define SCLKC_TG_TBEN 4

`define SCLKC_INT_MASTER 0
`define SCLKC_INT_TB 1

`define SCLKC_STOP_START 0
`define SCLKC_STOP_LEVEL 1
`define SCLKC_STOP_WARM_LO 8
`define SCLKC_STOP_WARM_HI 15

`define SCLKC_ST_TBINT 8

`define SCLKC_PRE_W 2
`define SCLKC_DIV_W 21
`define SCLKC_TB_TAP_BASE 5'd13
`define SCLKC_WARM_TAP_LO 13
`define SCLKC_STATES_PER_CYCLE 2'd3

`define SCLKC_RESP_OKAY 2'b00
`define SCLKC_RESP_SLVERR 2'b10

`endif

/* File: src/sclkc_top.v */
// Purpose: system clock mode controller with timing generator
// Assumes: fast and slow clock arrive as one-cycle ticks synchronous to clk
// Notes: registers reached over AXI4-Lite, 32-bit data, one word each
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "sclkc_defines.vh"

// Summary of operation
// - Timing generator: 2-stage prescaler, 21-stage divider, main clock, cycles
// - Prescaler and divider cleared on reset, stop entry and stop release
// - Slow run and sleep modes feed slow clock to stage seven
// - Warm-up after stop entered from fast run feeds stage six to seven
// - Machine cycle is four states, each one main clock period
// - Single clock: fast oscillator only, slow pins are ports, cycle 4/fc
// - Reset enters fast single run
// - Halt request in fast single run enters fast single halt
// - Interrupt releases halt; serviced if master enable, else resume next
// - Timing-generator halt in fast single run enters time-base-only wait
// - Falling edge of chosen tap ends wait, back to fast single run
// - After wait, interrupt serviced only if all three enables set
// - Wait entered with time base enabled sets time base interrupt
// - Dual clock: both oscillators, pins not ports, slow modes 4/fs
// - Main select moves fast/slow dual; fast osc enable slow only/dual
// - Slow-only modes stop stage one input, stages one to six idle
// - Fast dual halt like fast single halt, returns to fast dual run
// - Slow-only halt: slow osc only, peripherals on slow clock, wake
// - Slow dual halt like slow-only halt with fast oscillator running
// - Stop released by pin, level or edge; resume after warm-up
module sclkc_top (
    input wire clk,
    input wire rst_n,
    input wire [4:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [4:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire fast_clock_tick,
    input wire slow_clock_tick,
    input wire irq_request,
    input wire stop_release_in,
    output wire [3:0] mode,
    output wire cpu_clock_enable,
    output wire watchdog_clock_enable,
    output wire periph_clock_enable,
    output wire timebase_clock_enable,
    output wire fast_osc_run,
    output wire slow_osc_run,
    output wire slow_osc_pins_are_ports,
    output wire main_clock_tick,
    output reg [1:0] machine_state,
    output reg machine_cycle_end,
    output wire [`SCLKC_DIV_W-1:0] divider,
    output reg wake_int_service,
    output reg wake_resume_next,
    output reg timebase_interrupt
);

    localparam [3:0] M_FSR = 4'h0;
    localparam [3:0] M_FSH = 4'h1;
    localparam [3:0] M_TBW = 4'h2;
    localparam [3:0] M_FDR = 4'h3;
    localparam [3:0] M_FDH = 4'h4;
    localparam [3:0] M_SDR = 4'h5;
    localparam [3:0] M_SOR = 4'h6;
    localparam [3:0] M_SOH = 4'h7;
    localparam [3:0] M_SDH = 4'h8;
    localparam [3:0] M_STOP = 4'h9;
    localparam [3:0] M_WARM = 4'ha;

    reg [3:0] mode_reg;
    reg [3:0] mode_next;
    reg [3:0] ret_mode_reg;
    reg [7:0] sys_reg;
    reg [4:0] tg_reg;
    reg [1:0] int_reg;
    reg stop_level_reg;
    reg [7:0] warm_reg;
    reg [`SCLKC_PRE_W-1:0] pre_reg;
    reg [`SCLKC_DIV_W-1:0] div_reg;
    reg tb_prev_reg;
    reg tb_armed_reg;
    reg stop_pin_prev_reg;
    reg aw_have_reg;
    reg w_have_reg;
    reg [4:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;

    wire do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
    wire wr_sys = do_write && aw_addr_reg == `SCLKC_OFS_SYS_CTRL
        && w_strb_reg[0];
    wire wr_tg = do_write && aw_addr_reg == `SCLKC_OFS_TG_CTRL
        && w_strb_reg[0];
    wire wr_int = do_write && aw_addr_reg == `SCLKC_OFS_INT_CTRL
        && w_strb_reg[0];
    wire wr_stop = do_write && aw_addr_reg == `SCLKC_OFS_STOP_CTRL;
    wire wr_status = do_write && aw_addr_reg == `SCLKC_OFS_STATUS
        && w_strb_reg[1];
    wire halt_cmd = wr_sys && w_data_reg[`SCLKC_SYS_HALT];
    wire tg_halt_cmd = wr_sys && w_data_reg[`SCLKC_SYS_TG_HALT];
    wire stop_cmd = wr_stop && w_strb_reg[0]
        && w_data_reg[`SCLKC_STOP_START];
    wire wr_known = aw_addr_reg == `SCLKC_OFS_SYS_CTRL
        || aw_addr_reg == `SCLKC_OFS_TG_CTRL
        || aw_addr_reg == `SCLKC_OFS_INT_CTRL
        || aw_addr_reg == `SCLKC_OFS_STOP_CTRL
        || aw_addr_reg == `SCLKC_OFS_STATUS;

    wire fast_osc_en = sys_reg[`SCLKC_SYS_FAST_OSC];
    wire slow_osc_en = sys_reg[`SCLKC_SYS_SLOW_OSC];
    wire main_sel = sys_reg[`SCLKC_SYS_MAIN_SEL];
    wire dv7_sel = tg_reg[`SCLKC_TG_DV7];
    wire tb_en = tg_reg[`SCLKC_TG_TBEN];
    wire [2:0] tb_sel = tg_reg[`SCLKC_TG_TBSEL_HI:`SCLKC_TG_TBSEL_LO];
    wire master_int_enable = int_reg[`SCLKC_INT_MASTER];
    wire tb_ie = int_reg[`SCLKC_INT_TB];

    wire is_slow = mode_reg == M_SDR || mode_reg == M_SOR
        || mode_reg == M_SOH || mode_reg == M_SDH;
    wire is_slow_only = mode_reg == M_SOR || mode_reg == M_SOH;
    wire is_single = mode_reg == M_FSR || mode_reg == M_FSH
        || mode_reg == M_TBW;
    wire is_run = mode_reg == M_FSR || mode_reg == M_FDR
        || mode_reg == M_SDR || mode_reg == M_SOR;
    wire is_halt = mode_reg == M_FSH || mode_reg == M_FDH
        || mode_reg == M_SOH || mode_reg == M_SDH;
    wire in_stop = mode_reg == M_STOP || mode_reg == M_WARM;
    wire warm_from_fast = ret_mode_reg == M_FSR || ret_mode_reg == M_FDR;

    // Divider chain as a counter: each bit toggles on the carry of the one below, except stage seven, fed by stage7_in
    wire pre_carry = fast_clock_tick && pre_reg == {`SCLKC_PRE_W{1'b1}};
    wire stage1_in = pre_carry && !is_slow_only && mode_reg != M_STOP
        && !(mode_reg == M_WARM && !warm_from_fast);
    wire stage6_carry = stage1_in && div_reg[5:0] == 6'h3f;
    reg stage7_in;
    always @* begin
        if (mode_reg == M_WARM) begin
            stage7_in = warm_from_fast ? stage6_carry : slow_clock_tick;
        end else if (is_slow) begin
            stage7_in = slow_clock_tick;
        end else if (mode_reg == M_FDR || mode_reg == M_FDH) begin
            stage7_in = dv7_sel ? slow_clock_tick : stage6_carry;
        end else if (mode_reg == M_STOP) begin
            stage7_in = 1'b0;
        end else begin
            // Select bit ignored in single clock so a stray write is harmless
            stage7_in = stage6_carry;
        end
    end

    wire stop_entry = mode_reg != M_STOP && mode_next == M_STOP;
    wire stop_exit = mode_reg == M_STOP && mode_next == M_WARM;
    wire [4:0] tb_idx = `SCLKC_TB_TAP_BASE + {2'b00, tb_sel};
    wire tb_tap = div_reg[tb_idx];
    wire tb_fall = tb_prev_reg && !tb_tap;
    wire stop_pin_hit = stop_level_reg ? stop_release_in
        : (stop_release_in && !stop_pin_prev_reg);
    wire warm_done = div_reg[`SCLKC_DIV_W-1:`SCLKC_WARM_TAP_LO] >= warm_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg <= {`SCLKC_PRE_W{1'b0}};
            div_reg <= {`SCLKC_DIV_W{1'b0}};
            tb_prev_reg <= 1'b0;
            stop_pin_prev_reg <= 1'b0;
        end else begin
            tb_prev_reg <= tb_tap;
            stop_pin_prev_reg <= stop_release_in;
            if (stop_entry || stop_exit) begin
                pre_reg <= {`SCLKC_PRE_W{1'b0}};
                div_reg <= {`SCLKC_DIV_W{1'b0}};
            end else begin
                if (fast_clock_tick && !is_slow_only) begin
                    pre_reg <= pre_reg + 1'b1;
                end
                if (stage1_in) begin
                    div_reg[5:0] <= div_reg[5:0] + 1'b1;
                end
                if (stage7_in) begin
                    div_reg[20:6] <= div_reg[20:6] + 1'b1;
                end
            end
        end
    end

    // Mode sequencer; stop and halt commands win over oscillator enable changes
    always @* begin
        mode_next = mode_reg;
        case (mode_reg)
            M_FSR: begin
                if (stop_cmd) begin
                    mode_next = M_STOP;
                end else if (halt_cmd) begin
                    mode_next = M_FSH;
                end else if (tg_halt_cmd) begin
                    mode_next = M_TBW;
                end else if (slow_osc_en) begin
                    mode_next = M_FDR;
                end
            end
            M_FSH: begin
                if (irq_request) begin
                    mode_next = M_FSR;
                end
            end
            M_TBW: begin
                if (tb_fall) begin
                    mode_next = M_FSR;
                end
            end
            M_FDR: begin
                if (stop_cmd) begin
                    mode_next = M_STOP;
                end else if (halt_cmd) begin
                    mode_next = M_FDH;
                end else if (main_sel) begin
                    mode_next = M_SDR;
                end else if (!slow_osc_en) begin
                    mode_next = M_FSR;
                end
            end
            M_FDH: begin
                if (irq_request) begin
                    mode_next = M_FDR;
                end
            end
            M_SDR: begin
                if (stop_cmd) begin
                    mode_next = M_STOP;
                end else if (halt_cmd) begin
                    mode_next = M_SDH;
                end else if (!main_sel) begin
                    mode_next = M_FDR;
                end else if (!fast_osc_en) begin
                    mode_next = M_SOR;
                end
            end
            M_SOR: begin
                if (stop_cmd) begin
                    mode_next = M_STOP;
                end else if (halt_cmd) begin
                    mode_next = M_SOH;
                end else if (fast_osc_en) begin
                    mode_next = M_SDR;
                end
            end
            M_SOH: begin
                if (irq_request) begin
                    mode_next = M_SOR;
                end
            end
            M_SDH: begin
                if (irq_request) begin
                    mode_next = M_SDR;
                end
            end
            M_STOP: begin
                if (stop_pin_hit) begin
                    mode_next = M_WARM;
                end
            end
            M_WARM: begin
                if (warm_done) begin
                    mode_next = ret_mode_reg;
                end
            end
            default: begin
                mode_next = M_FSR;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= M_FSR;
            ret_mode_reg <= M_FSR;
            tb_armed_reg <= 1'b0;
            wake_int_service <= 1'b0;
            wake_resume_next <= 1'b0;
            timebase_interrupt <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            wake_int_service <= 1'b0;
            wake_resume_next <= 1'b0;
            if (stop_entry) begin
                ret_mode_reg <= mode_reg;
            end
            if (mode_reg == M_FSR && mode_next == M_TBW) begin
                tb_armed_reg <= tb_en;
            end
            if (is_halt && irq_request) begin
                wake_int_service <= master_int_enable;
                wake_resume_next <= !master_int_enable;
            end
            if (mode_reg == M_TBW && tb_fall) begin
                wake_int_service <= master_int_enable && tb_ie && tb_en;
                wake_resume_next <= !(master_int_enable && tb_ie && tb_en);
            end
            if (mode_reg == M_WARM && warm_done) begin
                wake_resume_next <= 1'b1;
            end
            // Hardware set wins over a clear in the same cycle
            if (mode_reg == M_TBW && tb_fall && tb_armed_reg) begin
                timebase_interrupt <= 1'b1;
            end else if (wr_status && w_data_reg[`SCLKC_ST_TBINT]) begin
                timebase_interrupt <= 1'b0;
            end
        end
    end

    assign main_clock_tick = is_slow ? slow_clock_tick
        : (!in_stop && fast_clock_tick);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            machine_state <= 2'b00;
            machine_cycle_end <= 1'b0;
        end else begin
            machine_cycle_end <= 1'b0;
            if (in_stop) begin
                machine_state <= 2'b00;
            end else if (main_clock_tick) begin
                machine_state <= machine_state + 1'b1;
                machine_cycle_end <=
                    machine_state == `SCLKC_STATES_PER_CYCLE;
            end
        end
    end

    assign mode = mode_reg;
    assign cpu_clock_enable = is_run;
    assign watchdog_clock_enable = is_run;
    assign periph_clock_enable = !in_stop && mode_reg != M_TBW;
    assign timebase_clock_enable = !in_stop;
    assign fast_osc_run = !is_slow_only
        && mode_reg != M_STOP && !(mode_reg == M_WARM && !warm_from_fast);
    assign slow_osc_run = !is_single && !in_stop;
    assign slow_osc_pins_are_ports = is_single;
    assign divider = div_reg;

    // Register bus: address and data taken in either order
    assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= 5'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SCLKC_RESP_OKAY;
            sys_reg <= `SCLKC_SYS_RESET;
            tg_reg <= 5'h00;
            int_reg <= 2'b00;
            stop_level_reg <= 1'b0;
            warm_reg <= 8'h00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[4:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? `SCLKC_RESP_OKAY
                    : `SCLKC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // Halt commands act once and are never stored
            if (wr_sys) begin
                sys_reg <= {w_data_reg[7:5], 5'b00000};
            end
            if (wr_tg) begin
                tg_reg <= w_data_reg[4:0];
            end
            if (wr_int) begin
                int_reg <= w_data_reg[1:0];
            end
            if (wr_stop && w_strb_reg[0]) begin
                stop_level_reg <= w_data_reg[`SCLKC_STOP_LEVEL];
            end
            if (wr_stop && w_strb_reg[1]) begin
                warm_reg <= w_data_reg[`SCLKC_STOP_WARM_HI:`SCLKC_STOP_WARM_LO];
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SCLKC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `SCLKC_RESP_OKAY;
            case ({s_axi_araddr[4:2], 2'b00})
                `SCLKC_OFS_SYS_CTRL: begin
                    // Main select reads back as the clock really in use
                    s_axi_rdata <= {24'h000000, sys_reg[7:6], is_slow,
                        5'b00000};
                end
                `SCLKC_OFS_TG_CTRL: begin
                    s_axi_rdata <= {27'h0000000, tg_reg};
                end
                `SCLKC_OFS_INT_CTRL: begin
                    s_axi_rdata <= {30'h00000000, int_reg};
                end
                `SCLKC_OFS_STOP_CTRL: begin
                    s_axi_rdata <= {16'h0000, warm_reg, 6'h00,
                        stop_level_reg, 1'b0};
                end
                `SCLKC_OFS_STATUS: begin
                    s_axi_rdata <= {23'h000000, timebase_interrupt, 2'b00,
                        machine_state, mode_reg};
                end
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `SCLKC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule
`default_nettype wire

/* File: test/sclkc_chk_assertions.sv */
// Purpose: port checks of the system clock mode controller
// Assumes: one clock domain, rst_n active low
// Notes: bound to sclkc_top below
`timescale 1ns/100ps
`default_nettype none
module sclkc_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fast_clock_tick,
    input wire logic slow_clock_tick,
    input wire logic irq_request,
    input wire logic [3:0] mode,
    input wire logic cpu_clock_enable,
    input wire logic watchdog_clock_enable,
    input wire logic periph_clock_enable,
    input wire logic timebase_clock_enable,
    input wire logic fast_osc_run,
    input wire logic slow_osc_run,
    input wire logic slow_osc_pins_are_ports,
    input wire logic main_clock_tick,
    input wire logic [1:0] machine_state,
    input wire logic [20:0] divider
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    wire logic slow_m = mode >= 4'd5 && mode <= 4'd8;
    wire logic fast_off = mode == 4'd6 || mode == 4'd7;
    AST_HALT_GATES:
    assert property ((mode == 4'd1 || mode == 4'd4) |-> !cpu_clock_enable &&
        !watchdog_clock_enable && periph_clock_enable)
        else $error("halt gating wrong");
    AST_WAIT_GATES:
    assert property (mode == 4'd2 |-> !cpu_clock_enable &&
        !periph_clock_enable && timebase_clock_enable)
        else $error("time base wait gating wrong");
    AST_SINGLE_OSC:
    assert property (mode <= 4'd2 |-> slow_osc_pins_are_ports &&
        !slow_osc_run && fast_osc_run)
        else $error("single clock oscillators wrong");
    AST_DUAL_OSC:
    assert property (mode >= 4'd3 && mode <= 4'd8 |-> slow_osc_run &&
        !slow_osc_pins_are_ports && fast_osc_run != fast_off)
        else $error("dual clock oscillators wrong");
    AST_MAIN_TICK:
    assert property (mode <= 4'd8 |-> main_clock_tick ==
        (slow_m ? slow_clock_tick : fast_clock_tick))
        else $error("main clock source wrong");
    AST_STAGE_IDLE:
    assert property (fast_off ##1 fast_off |-> $stable(divider[5:0]))
        else $error("low stages moved without fast clock");
    AST_STATE_ADV:
    assert property (mode <= 4'd8 |=> mode > 4'd8 || machine_state ==
        $past(machine_state) + {1'b0, $past(main_clock_tick)})
        else $error("machine state step wrong");
    AST_SINGLE_WAKE:
    assert property (mode == 4'd1 && irq_request |=> mode == 4'd0)
        else $error("single halt not woken");
    AST_DUAL_WAKE:
    assert property ((mode == 4'd4 || mode == 4'd7 || mode == 4'd8) &&
        irq_request |=> mode == ($past(mode) == 4'd8 ? 4'd5 : $past(mode) - 4'd1))
        else $error("dual halt not woken");
endmodule
bind sclkc_top sclkc_chk u_chk (.clk, .rst_n, .fast_clock_tick,
    .slow_clock_tick, .irq_request, .mode, .cpu_clock_enable,
    .watchdog_clock_enable, .periph_clock_enable, .timebase_clock_enable,
    .fast_osc_run, .slow_osc_run, .slow_osc_pins_are_ports,
    .main_clock_tick, .machine_state, .divider);
`default_nettype wire

/* File: test/sclkc_osc_model.sv */
// Purpose: oscillator model at the far side of the controller
// Assumes: ticks synchronous to clk
// Notes: fast ticks every cycle, slow ticks one in SLOW_DIV
`timescale 1ns/100ps
`default_nettype none
module sclkc_osc_model #(
    parameter int SLOW_DIV = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fast_osc_run,
    input wire logic slow_osc_run,
    output logic fast_clock_tick,
    output logic slow_clock_tick
);
    int cnt;
    // A stopped oscillator gives no ticks, so no stage can creep on
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            fast_clock_tick <= 1'b0;
            slow_clock_tick <= 1'b0;
        end else begin
            cnt <= (cnt + 1) % SLOW_DIV;
            fast_clock_tick <= fast_osc_run;
            slow_clock_tick <= slow_osc_run && cnt == 0;
        end
    end
endmodule
`default_nettype wire

/* File: test/tb_system_clock_mode_controller.sv */
// Purpose: self-checking bench of the clock mode controller
// Assumes: bready and rready held high, full byte strobes
// Notes: the time base wait may take some 66k cycles on tap 13
`timescale 1ns/100ps
`default_nettype none
`include "sclkc_defines.vh"
module tb_system_clock_mode_controller;
    logic clk = 1'b0, rst_n = 1'b0, irq_request = 1'b0;
    logic stop_release_in = 1'b0, master_int_enable, seen;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, d, seed;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic [1:0] r;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire logic s_axi_rvalid, fast_clock_tick, slow_clock_tick;
    wire logic fast_osc_run, slow_osc_run, slow_osc_pins_are_ports;
    wire logic wake_int_service, wake_resume_next, timebase_interrupt;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [3:0] mode;
    wire logic [20:0] divider;
    int err_count = 0, n_compared = 0, exp_mode = 0;
    // Wake flag, expected mode, system control value
    logic [12:0] seq [9] = '{13'h03c0, 13'h14d0, 13'h05e0, 13'h0660,
        13'h1770, 13'h05e0, 13'h18f0, 13'h03c0, 13'h0080};
    sclkc_top uut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fast_clock_tick,
        .slow_clock_tick, .irq_request, .stop_release_in, .mode,
        .cpu_clock_enable(), .watchdog_clock_enable(),
        .periph_clock_enable(), .timebase_clock_enable(), .fast_osc_run,
        .slow_osc_run, .slow_osc_pins_are_ports, .main_clock_tick(),
        .machine_state(), .machine_cycle_end(), .divider,
        .wake_int_service, .wake_resume_next, .timebase_interrupt);
    sclkc_osc_model u_osc (.clk, .rst_n, .fast_osc_run, .slow_osc_run,
        .fast_clock_tick, .slow_clock_tick);
    always #25 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
    endtask
    task automatic rd(input logic [4:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic step(input logic [7:0] v, input int m);
        wr(`SCLKC_OFS_SYS_CTRL, {24'h0, v});
        chk("bresp", 0, r);
        exp_mode = m;
        repeat (2) @(posedge clk);
        chk("mode", exp_mode, mode);
    endtask
    // Wake lands one edge after the request is seen
    task automatic wake();
        irq_request <= 1'b1;
        @(posedge clk);
        irq_request <= 1'b0;
        @(posedge clk);
        exp_mode = (exp_mode == 8) ? 5 : exp_mode - 1;
        chk("mode", exp_mode, mode);
        chk("service", master_int_enable, wake_int_service);
        chk("resume", !master_int_enable, wake_resume_next);
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk);
        err_count++;
        complete_run();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("mode", 0, mode);
        chk("divider", 0, divider);
        chk("pins", 1, slow_osc_pins_are_ports);
        rd(`SCLKC_OFS_SYS_CTRL);
        chk("sys", 32'h80, d);
        rd(5'h14);
        chk("rresp", 2, r);
        chk("rdata", 0, d);
        wr(5'h14, 32'hffffffff);
        chk("bresp", 2, r);
        seed = xs(32'heced);
        wr(`SCLKC_OFS_INT_CTRL, seed & 32'hfffffffe);
        rd(`SCLKC_OFS_INT_CTRL);
        chk("int_ctrl", seed & 32'h2, d);
        master_int_enable = 1'b0;
        step(8'h90, 1);
        wake();
        wr(`SCLKC_OFS_TG_CTRL, 32'h10);
        wr(`SCLKC_OFS_INT_CTRL, 32'h3);
        master_int_enable = 1'b1;
        step(8'h84, 2);
        seen = 1'b0;
        do begin
            @(posedge clk);
            seen = seen | (wake_int_service === 1'b1);
        end while (mode === 4'd2);
        chk("mode", 0, mode);
        chk("tb_service", 1, seen);
        repeat (2) @(posedge clk);
        chk("tb_latch", 1, timebase_interrupt);
        wr(`SCLKC_OFS_STATUS, 32'h100);
        @(posedge clk);
        chk("tb_clear", 0, timebase_interrupt);
        foreach (seq[i]) begin
            step(seq[i][7:0], seq[i][11:8]);
            if (seq[i][12]) wake();
        end
        wr(`SCLKC_OFS_STOP_CTRL, 32'h3);
        repeat (2) @(posedge clk);
        chk("mode", 9, mode);
        chk("divider", 0, divider);
        stop_release_in <= 1'b1;
        do begin
            @(posedge clk);
        end while (mode !== 4'd0);
        stop_release_in <= 1'b0;
        chk("warm_clear", 0, divider[20:13]);
        complete_run();
    end
endmodule
`default_nettype wire
